// ---- misc_glue_map.svh ----
// Offsets, field positions and reset values for the runtime glue register slice.
// Assumes an 8-bit register address and 8-bit data on the software port.
`ifndef MISC_GLUE_MAP_SVH
`define MISC_GLUE_MAP_SVH

// ==========================================================================
// Register offsets
`define OFS_FORCE_MEDIA 8'h18
`define OFS_RATE_SHADOW 8'h19
`define OFS_SER1_SHADOW 8'h1A
`define OFS_IRQ_BANK_A 8'h1B
`define OFS_IRQ_BANK_B 8'h1C
`define OFS_SER2_SHADOW 8'h1D
`define OFS_RSVD_LOW 8'h1E
`define OFS_RSVD_HIGH 8'h1F
`define OFS_EVENT_STATUS 8'h20
`define OFS_EVENT_MASK 8'h21

// ==========================================================================
// Field positions and masks
`define FORCE_LATCH_BIT 0
`define BANK_A_RSVD_BIT 0
`define RATE_SHADOW_MASK 8'hDF
`define FIFO_SHADOW_MASK 8'hCF
`define EVT_LATCH_CLEARED 0
`define EVT_MEDIA_CHANGED 1

// ==========================================================================
// Reset values
`define RST_FORCE_LATCH 1'b1
`define RST_IRQ_BANK 8'hFF
`define RST_EVENTS 2'h0
`define READ_ZERO 8'h00

`endif

// ---- misc_glue_pkg.sv ----
// Types shared by the runtime glue register slice.
// Assumes misc_glue_map.svh supplies all numeric constants.
`default_nettype none

package misc_glue_pkg;

  // ========================================================================
  // Software register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // ========================================================================
  // Shadow inputs from the floppy and serial cores
  typedef struct packed {
    logic [7:0] rate;
    logic [7:0] serial1_fcr;
    logic [7:0] serial2_fcr;
  } shadow_type;

  // ========================================================================
  // Whole state of the block
  typedef struct packed {
    logic force_latch;
    logic [7:0] bank_a;
    logic [7:0] bank_b;
    logic [7:0] rd_data;
    logic step_prev;
    logic media_flag;
    logic [15:0] frames_n;
    logic [1:0] events;
    logic [1:0] mask;
    logic irq;
  } state_type;

endpackage

`default_nettype wire

// ---- misc_runtime_regs.sv ----
// Runtime glue register slice: forced media change, floppy and serial
// shadows, and two software interrupt-generating banks.
// Assumes all inputs are synchronous to CORE_CLK and that the serial IRQ
// encoder samples IRQ_FRAME_N with its own ordinary frame timing.
//
// Decided for this implementation: the address-and-strobe port.
`include "misc_glue_map.svh"
`default_nettype none

// How it works
// - Bit 0 at 0x18: write-one set, resets to one
// - Latch cleared only by step with drive select
// - Media flag = (DRIVE_SELECT0_N AND latch) OR MEDIA_CHANGE_IN_N
// - Floppy rate shadow read-only at 0x19
// - First serial FIFO control shadow at 0x1A
// - Second serial FIFO control shadow at 0x1D
// - Bank A bits 7:1 drive frames 7..1
// - Bank B bits 0..7 drive frames 8..15
// - Banks act only while configuration enable set
// - Banks read back; written value is stored, except bank A bit 0, which keeps its value
// - Zero bank bit overrides other frame sources
// - Only software writes and HARD_RESET (back to all ones) change bank bits
// - Offsets 0x1E and 0x1F read zero
module misc_runtime_regs (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  input wire logic [7:0] FLOPPY_RATE_IN,
  input wire logic [7:0] SERIAL1_FCR_IN,
  input wire logic [7:0] SERIAL2_FCR_IN,
  input wire logic HEAD_STEP_PULSE_N,
  input wire logic DRIVE_SELECT0_N,
  input wire logic MEDIA_CHANGE_IN_N,
  output logic MEDIA_CHANGED_FLAG,
  input wire logic IRQ_GEN_ENABLE,
  input wire logic HARD_RESET,
  input wire logic [15:0] IRQ_SOURCE_N,
  output logic [15:0] IRQ_FRAME_N,
  output logic IRQ
);
  import misc_glue_pkg::*;

  // ========================================================================
  // Reset release
  // Assertion is asynchronous, release goes through two flops so every
  // register leaves reset on the same edge.
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ========================================================================
  // Decoding helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] merge_low_bank(
    input logic [7:0] cur,
    input logic [7:0] wd
  );
    // Writing zero clears a bit, writing one restores it: plain store of bits 7:1; bit 0 keeps its current value
    merge_low_bank = wd;
    merge_low_bank[`BANK_A_RSVD_BIT] = cur[`BANK_A_RSVD_BIT];
  endfunction

  // ========================================================================
  // Port bundles
  reg_req_type req;
  shadow_type shadow;

  always_comb begin
    req.addr = ADDR;
    req.wdata = WR_DATA;
    req.wr = WR_STB;
    req.rd = RD_STB;
  end

  always_comb begin
    shadow.rate = FLOPPY_RATE_IN;
    shadow.serial1_fcr = SERIAL1_FCR_IN;
    shadow.serial2_fcr = SERIAL2_FCR_IN;
  end

  // ========================================================================
  // State
  state_type state;
  state_type next_state;
  state_type reset_state;

  always_comb begin
    reset_state = '0;
    reset_state.force_latch = `RST_FORCE_LATCH;
    reset_state.bank_a = `RST_IRQ_BANK;
    reset_state.bank_b = `RST_IRQ_BANK;
    reset_state.rd_data = `READ_ZERO;
    reset_state.step_prev = 1'b1;
    reset_state.media_flag = 1'b0;
    reset_state.frames_n = {16{1'b1}};
    reset_state.events = `RST_EVENTS;
    reset_state.mask = `RST_EVENTS;
    reset_state.irq = 1'b0;
  end

  // ========================================================================
  // Write decode
  logic wr_force;
  logic wr_bank_a;
  logic wr_bank_b;
  logic wr_mask;
  logic rd_status;

  always_comb begin
    wr_force = req.wr && hit(req.addr, `OFS_FORCE_MEDIA);
    wr_bank_a = req.wr && hit(req.addr, `OFS_IRQ_BANK_A);
    wr_bank_b = req.wr && hit(req.addr, `OFS_IRQ_BANK_B);
    wr_mask = req.wr && hit(req.addr, `OFS_EVENT_MASK);
    rd_status = req.rd && hit(req.addr, `OFS_EVENT_STATUS);
  end

  // ========================================================================
  // Drive activity
  // A step falling edge while drive 0 is selected counts as drive activity.
  logic step_fall;
  logic drive_activity;

  always_comb begin
    step_fall = state.step_prev && !HEAD_STEP_PULSE_N;
    drive_activity = step_fall && !DRIVE_SELECT0_N;
  end

  // ========================================================================
  // Forced media-change latch
  logic next_latch;

  always_comb begin
    next_latch = state.force_latch;
    if (drive_activity) begin
      next_latch = 1'b0;
    end
    // A set write in the same cycle as drive activity wins
    if (wr_force && req.wdata[`FORCE_LATCH_BIT]) begin
      next_latch = 1'b1;
    end
  end

  // ========================================================================
  // Media-changed flag
  logic next_media_flag;

  always_comb begin
    next_media_flag = (DRIVE_SELECT0_N & next_latch) | MEDIA_CHANGE_IN_N;
  end

  // ========================================================================
  // Interrupt-generating banks
  // Software writes land here; the only hardware path is HARD_RESET, which reloads all ones.
  logic [7:0] next_bank_a;
  logic [7:0] next_bank_b;

  always_comb begin
    next_bank_a = state.bank_a;
    next_bank_b = state.bank_b;
    if (HARD_RESET) begin
      next_bank_a = reset_state.bank_a;
      next_bank_b = reset_state.bank_b;
    end else begin
      if (wr_bank_a) begin
        next_bank_a = merge_low_bank(state.bank_a, req.wdata);
      end
      if (wr_bank_b) begin
        next_bank_b = req.wdata;
      end
    end
  end

  // ========================================================================
  // Frame merge toward the serial IRQ encoder
  // Frame 0 has no bank bit, so it passes the other source straight through.
  logic [15:0] bank_frames_n;
  logic [15:0] next_frames_n;

  always_comb begin
    bank_frames_n = {next_bank_b, next_bank_a[7:1], 1'b1};
  end

  genvar f;
  generate
    for (f = 0; f < 16; f = f + 1) begin : g_frame
      always_comb begin
        // Low wins: with IRQ_GEN_ENABLE set, the bank pulls the frame down whatever the source does
        next_frames_n[f] = IRQ_SOURCE_N[f] & (bank_frames_n[f] | !IRQ_GEN_ENABLE);
      end
    end
  endgenerate

  // ========================================================================
  // Event status and mask
  logic [1:0] event_set;
  logic [1:0] next_events;
  logic [1:0] next_mask;

  always_comb begin
    event_set = 2'h0;
    event_set[`EVT_LATCH_CLEARED] = state.force_latch && !next_latch;
    event_set[`EVT_MEDIA_CHANGED] = next_media_flag && !state.media_flag;
  end

  always_comb begin
    next_events = state.events;
    if (rd_status) begin
      next_events = `RST_EVENTS;
    end
    // Setting beats the clear of a read in the same cycle
    next_events = next_events | event_set;
  end

  always_comb begin
    next_mask = state.mask;
    if (wr_mask) begin
      next_mask = req.wdata[1:0];
    end
  end

  // ========================================================================
  // Read mux
  // Data stand only in the cycle after the strobe; otherwise zero.
  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = `READ_ZERO;
    if (req.rd) begin
      if (hit(req.addr, `OFS_FORCE_MEDIA)) begin
        next_rd_data[`FORCE_LATCH_BIT] = state.force_latch;
      end else if (hit(req.addr, `OFS_RATE_SHADOW)) begin
        next_rd_data = shadow.rate & `RATE_SHADOW_MASK;
      end else if (hit(req.addr, `OFS_SER1_SHADOW)) begin
        next_rd_data = shadow.serial1_fcr & `FIFO_SHADOW_MASK;
      end else if (hit(req.addr, `OFS_IRQ_BANK_A)) begin
        next_rd_data = state.bank_a;
      end else if (hit(req.addr, `OFS_IRQ_BANK_B)) begin
        next_rd_data = state.bank_b;
      end else if (hit(req.addr, `OFS_SER2_SHADOW)) begin
        next_rd_data = shadow.serial2_fcr & `FIFO_SHADOW_MASK;
      end else if (hit(req.addr, `OFS_RSVD_LOW) || hit(req.addr, `OFS_RSVD_HIGH)) begin
        next_rd_data = `READ_ZERO;
      end else if (hit(req.addr, `OFS_EVENT_STATUS)) begin
        next_rd_data[1:0] = state.events;
      end else if (hit(req.addr, `OFS_EVENT_MASK)) begin
        next_rd_data[1:0] = state.mask;
      end else begin
        next_rd_data = `READ_ZERO;
      end
    end
  end

  // ========================================================================
  // Next state
  always_comb begin
    next_state = state;
    next_state.force_latch = next_latch;
    next_state.bank_a = next_bank_a;
    next_state.bank_b = next_bank_b;
    next_state.rd_data = next_rd_data;
    next_state.step_prev = HEAD_STEP_PULSE_N;
    next_state.media_flag = next_media_flag;
    next_state.frames_n = next_frames_n;
    next_state.events = next_events;
    next_state.mask = next_mask;
    next_state.irq = |(next_events & next_mask);
  end

  // ========================================================================
  // Registers
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.force_latch <= `RST_FORCE_LATCH;
      state.bank_a <= `RST_IRQ_BANK;
      state.bank_b <= `RST_IRQ_BANK;
      state.step_prev <= 1'b1;
      state.frames_n <= {16{1'b1}};
    end else begin
      state <= next_state;
    end
  end

  // ========================================================================
  // Outputs, all straight from flops
  always_comb begin
    RD_DATA = state.rd_data;
    MEDIA_CHANGED_FLAG = state.media_flag;
    IRQ_FRAME_N = state.frames_n;
    IRQ = state.irq;
  end

endmodule // misc_runtime_regs

`default_nettype wire

// ---- misc_glue_sva.sv ----
// Checker for the runtime glue slice, bound to misc_runtime_regs.
// Assumes one clock domain and the two-flop reset release.
`default_nettype none
module misc_glue_sva (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] RD_DATA,
  input wire logic [7:0] FLOPPY_RATE_IN,
  input wire logic [7:0] SERIAL1_FCR_IN,
  input wire logic [7:0] SERIAL2_FCR_IN,
  input wire logic MEDIA_CHANGE_IN_N,
  input wire logic MEDIA_CHANGED_FLAG,
  input wire logic IRQ_GEN_ENABLE,
  input wire logic [15:0] IRQ_SOURCE_N,
  input wire logic [15:0] IRQ_FRAME_N
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Reset trail
  logic [1:0] up;
  // Internal reset trails NRST by two edges, so wait it out
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  wire logic live = (up == 2'h3);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // ==========================================================================
  // Properties
  rsvd_zero_a: assert property (live && RD_STB && ADDR[7:1] == 7'h0F |=> RD_DATA == 8'h00)
    else $error("reserved read not zero");
  rate_shadow_a: assert property (live && RD_STB && ADDR == 8'h19 |=> RD_DATA == ($past(FLOPPY_RATE_IN) & 8'hDF))
    else $error("rate shadow wrong");
  ser1_shadow_a: assert property (live && RD_STB && ADDR == 8'h1A |=> RD_DATA == ($past(SERIAL1_FCR_IN) & 8'hCF))
    else $error("serial 1 shadow wrong");
  ser2_shadow_a: assert property (live && RD_STB && ADDR == 8'h1D |=> RD_DATA == ($past(SERIAL2_FCR_IN) & 8'hCF))
    else $error("serial 2 shadow wrong");
  latch_read_a: assert property (live && RD_STB && ADDR == 8'h18 |=> RD_DATA[7:1] == 7'h00)
    else $error("latch register upper bits set");
  bank_rsvd_a: assert property (live && RD_STB && ADDR == 8'h1B |=> RD_DATA[0])
    else $error("bank a bit 0 not one");
  source_pass_a: assert property (live |=> (IRQ_FRAME_N & ~$past(IRQ_SOURCE_N)) == 16'h0000)
    else $error("low source not passed");
  disabled_a: assert property (live && !IRQ_GEN_ENABLE |=> IRQ_FRAME_N == $past(IRQ_SOURCE_N))
    else $error("bank acts while disabled");
  bank_zero_a: assert property (live && WR_STB && ADDR == 8'h1C && !WR_DATA[0] && IRQ_GEN_ENABLE
    |=> ##[0:1] !IRQ_FRAME_N[8])
    else $error("frame 8 not forced low");
  media_in_a: assert property (live && MEDIA_CHANGE_IN_N |=> MEDIA_CHANGED_FLAG)
    else $error("media flag ignores input");
  rd_quiet_a: assert property (live && !RD_STB |=> RD_DATA == 8'h00)
    else $error("read data stands outside its cycle");
  cover property (live && RD_STB && ADDR == 8'h1B);
  cover property (live && !IRQ_FRAME_N[8]);
  cover property (live && $fell(MEDIA_CHANGED_FLAG));
endmodule // misc_glue_sva

bind misc_runtime_regs misc_glue_sva chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR),
  .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
  .FLOPPY_RATE_IN(FLOPPY_RATE_IN), .SERIAL1_FCR_IN(SERIAL1_FCR_IN), .SERIAL2_FCR_IN(SERIAL2_FCR_IN),
  .MEDIA_CHANGE_IN_N(MEDIA_CHANGE_IN_N), .MEDIA_CHANGED_FLAG(MEDIA_CHANGED_FLAG),
  .IRQ_GEN_ENABLE(IRQ_GEN_ENABLE), .IRQ_SOURCE_N(IRQ_SOURCE_N), .IRQ_FRAME_N(IRQ_FRAME_N));
`default_nettype wire

// ---- glue_host.sv ----
// Host-side register master for the glue slice bench.
// Assumes the slice answers a read in the cycle after the strobe.
`default_nettype none
module glue_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Released lines show the inverse, so stale values never look valid
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
    // Return on an edge so the caller's next drive lands on a rising edge
    @(posedge clk);
  endtask
endmodule // glue_host
`default_nettype wire

// ---- misc_runtime_glue_regs_tb.sv ----
// Self-checking bench for the runtime glue slice.
// Assumes glue_host drives the register port and the checker is bound.
`default_nettype none
module misc_runtime_glue_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] v;} row_type;
  logic clk = 1'b0;
  logic nrst, wr, rd, step_n, ds0_n, media_n, flag, en, hard, irq;
  logic [7:0] addr, wdata, rdata, rate, s1, s2, d;
  logic [15:0] src_n, frame_n, exp;
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;
  row_type rows [0:18];
  always #2 clk = ~clk;
  glue_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  misc_runtime_regs dut (.CORE_CLK(clk), .NRST(nrst), .ADDR(addr), .WR_DATA(wdata), .WR_STB(wr),
    .RD_STB(rd), .RD_DATA(rdata), .FLOPPY_RATE_IN(rate), .SERIAL1_FCR_IN(s1), .SERIAL2_FCR_IN(s2),
    .HEAD_STEP_PULSE_N(step_n), .DRIVE_SELECT0_N(ds0_n), .MEDIA_CHANGE_IN_N(media_n),
    .MEDIA_CHANGED_FLAG(flag), .IRQ_GEN_ENABLE(en), .HARD_RESET(hard), .IRQ_SOURCE_N(src_n),
    .IRQ_FRAME_N(frame_n), .IRQ(irq));
  // ==========================================================================
  // Reporting
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
    n_tests++;
    if (got !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      close_out();
    end
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ==========================================================================
  // Sequence
  initial begin
    nrst = 1'b0;
    rate = 8'hFF;
    s1 = 8'h3F;
    s2 = 8'hF5;
    step_n = 1'b1;
    ds0_n = 1'b1;
    media_n = 1'b1;
    en = 1'b0;
    hard = 1'b0;
    src_n = 16'hFFFF;
    rows = '{'{1'b0, 8'h18, 8'h01}, '{1'b0, 8'h1B, 8'hFF}, '{1'b0, 8'h1C, 8'hFF}, '{1'b0, 8'h19, 8'hDF},
      '{1'b0, 8'h1A, 8'h0F}, '{1'b0, 8'h1D, 8'hC5}, '{1'b0, 8'h1E, 8'h00}, '{1'b0, 8'h1F, 8'h00},
      '{1'b0, 8'h30, 8'h00}, '{1'b1, 8'h19, 8'hA5}, '{1'b0, 8'h19, 8'hDF}, '{1'b1, 8'h1E, 8'h55},
      '{1'b0, 8'h1E, 8'h00}, '{1'b1, 8'h1B, 8'h00}, '{1'b0, 8'h1B, 8'h01}, '{1'b1, 8'h1C, 8'h5A},
      '{1'b0, 8'h1C, 8'h5A}, '{1'b1, 8'h18, 8'h00}, '{1'b0, 8'h18, 8'h01}};
    settle(7);
    check("reset frames", 16'hFFFF, frame_n);
    check("reset outputs", 16'h0000, {6'h00, irq, flag, rdata});
    @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) host.wr_reg(rows[i].a, rows[i].v);
      else begin
        host.rd_reg(rows[i].a, d);
        check("register read", {8'h00, rows[i].v}, {8'h00, d});
      end
    end
    $display("register table done");
    host.wr_reg(8'h1B, 8'hFF);
    host.wr_reg(8'h1C, 8'hFF);
    en <= 1'b1;
    for (int i = 1; i < 16; i++) begin
      exp = ~(16'h0001 << i);
      host.wr_reg(i < 8 ? 8'h1B : 8'h1C, i < 8 ? exp[7:0] : exp[15:8]);
      settle(1);
      check("frame pattern", exp, frame_n);
      host.wr_reg(i < 8 ? 8'h1B : 8'h1C, 8'hFF);
    end
    src_n <= 16'h7FFE;
    settle(2);
    check("source low passes", 16'h7FFE, frame_n);
    host.wr_reg(8'h1C, 8'h00);
    en <= 1'b0;
    src_n <= 16'hBFFE;
    settle(2);
    check("frames disabled", 16'hBFFE, frame_n);
    host.rd_reg(8'h1C, d);
    check("bank kept", 16'h0000, {8'h00, d});
    src_n <= 16'hFFFF;
    hard <= 1'b1;
    @(posedge clk);
    hard <= 1'b0;
    host.rd_reg(8'h1C, d);
    check("hard reset bank", 16'h00FF, {8'h00, d});
    $display("frame tests done");
    media_n <= 1'b0;
    host.rd_reg(8'h20, d);
    host.wr_reg(8'h21, 8'h01);
    step_n <= 1'b0;
    host.rd_reg(8'h18, d);
    check("latch kept", 16'h0001, {8'h00, d});
    step_n <= 1'b1;
    ds0_n <= 1'b0;
    settle(2);
    @(posedge clk);
    step_n <= 1'b0;
    settle(3);
    check("media flag", 16'h0000, {15'h0000, flag});
    check("irq raised", 16'h0001, {15'h0000, irq});
    host.rd_reg(8'h18, d);
    check("latch cleared", 16'h0000, {8'h00, d});
    host.rd_reg(8'h20, d);
    check("event status", 16'h0001, {15'h0000, d[0]});
    settle(2);
    check("irq cleared", 16'h0000, {15'h0000, irq});
    @(posedge clk);
    ds0_n <= 1'b1;
    step_n <= 1'b1;
    host.wr_reg(8'h18, 8'h01);
    settle(2);
    check("media flag forced", 16'h0001, {15'h0000, flag});
    check("irq masked", 16'h0000, {15'h0000, irq});
    host.wr_reg(8'h21, 8'h03);
    settle(2);
    check("irq unmasked", 16'h0001, {15'h0000, irq});
    $display("latch tests done");
    close_out();
  end
endmodule // misc_runtime_glue_regs_tb
`default_nettype wire
